/* logic/sjtap_pkg.sv */
/*
 Constants for the memory test access port: instruction codes,
 scan register lengths, identification field layout.
 Assumes nothing of its surroundings.
*/
package sjtap_pkg;
  // ==========================================================
  // Scan register lengths and the output enable cell
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN = 107;
  localparam int OE_CELL = 47;
  // ==========================================================
  // Instruction codes
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  // Value captured into the instruction register
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // ==========================================================
  // Identification fields; values arbitrary, not any real maker
  localparam logic [2:0] ID_REV = 3'h0;
  localparam logic [16:0] ID_PART = 17'h0_1234;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic ID_PRESENT = 1'b1;
  // ==========================================================
  // Controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
  } sjtap_state_t;
endpackage

/* logic/sjtap_sync.sv */
/*
 Two flip-flop level synchroniser into the system clock.
 Assumes an asynchronous source.
*/
`timescale 1ns/1ps
module sjtap_sync import sjtap_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
  } sjtap_sync_t;
  sjtap_sync_t r, nxt_r;
  always_comb begin
    nxt_r = r;
    nxt_r.s1_ff = d;
    nxt_r.s2_ff = r.s1_ff;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= nxt_r;
    end
  end
  assign q = r.s2_ff;
endmodule

/* logic/sjtap_top.sv */
/*
 Boundary-scan test access port of a burst memory. Runs on tck;
 the output tristate control crosses to ref_clk via sjtap_sync.
 Assumes pin states arrive on pin_in and the board controller
 drives tck, tms, tdi and trst_n-free operation via rstn.
*/
`timescale 1ns/1ps
module sjtap_top import sjtap_pkg::*; #(
  parameter int NCELL = BSR_LEN
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [NCELL-1:0] pin_in,
  output logic [NCELL-1:0] cell_out,
  output logic ext_mode,
  output logic q_oe_n
);
  typedef struct packed {
    sjtap_state_t st_ff;
    logic [IR_LEN-1:0] ir_sh_ff;
    logic [IR_LEN-1:0] ir_ff;
    logic [ID_LEN-1:0] dr_id_ff;
    logic byp_ff;
    logic [NCELL-1:0] bsr_ff;
    logic [NCELL-1:0] upd_ff;
    logic tdo_ff;
    logic oe_n_ff;
    logic qz_ff;
  } sjtap_regs_t;
  sjtap_regs_t r, nxt_r;
  logic [ID_LEN-1:0] id_word;
  logic sel_bsr;
  logic q_off_sync;
  // ==========================================================
  // Identification word
  assign id_word = {ID_REV, ID_PART, ID_MAKER, ID_PRESENT};
  assign sel_bsr = (r.ir_ff == INS_EXTEST) || (r.ir_ff == INS_SAMPLEZ) ||
                   (r.ir_ff == INS_SAMPLE);
  // ==========================================================
  // Controller and scan registers
  always_comb begin
    nxt_r = r;
    case (r.st_ff)
      ST_RESET: nxt_r.st_ff = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: nxt_r.st_ff = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_r.st_ff = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_r.st_ff = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_r.st_ff = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_r.st_ff = tms ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR: nxt_r.st_ff = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: nxt_r.st_ff = tms ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR: nxt_r.st_ff = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_r.st_ff = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nxt_r.st_ff = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_r.st_ff = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_r.st_ff = tms ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR: nxt_r.st_ff = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: nxt_r.st_ff = tms ? ST_UP_IR : ST_SH_IR;
      ST_UP_IR: nxt_r.st_ff = tms ? ST_SEL_DR : ST_IDLE;
      default: nxt_r.st_ff = ST_RESET;
    endcase
    case (r.st_ff)
      ST_RESET: begin
        nxt_r.ir_ff = INS_IDCODE;
        nxt_r.upd_ff[OE_CELL] = 1'b1;
      end
      ST_CAP_IR: nxt_r.ir_sh_ff = IR_CAPTURE;
      ST_SH_IR: nxt_r.ir_sh_ff = {tdi, r.ir_sh_ff[IR_LEN-1:1]};
      ST_UP_IR: nxt_r.ir_ff = r.ir_sh_ff;
      ST_CAP_DR: begin
        if (r.ir_ff == INS_IDCODE) begin
          nxt_r.dr_id_ff = id_word;
        end else if (sel_bsr) begin
          nxt_r.bsr_ff = pin_in;
        end else begin
          nxt_r.byp_ff = 1'b0;
        end
      end
      ST_SH_DR: begin
        if (r.ir_ff == INS_IDCODE) begin
          nxt_r.dr_id_ff = {tdi, r.dr_id_ff[ID_LEN-1:1]};
        end else if (sel_bsr) begin
          nxt_r.bsr_ff = {tdi, r.bsr_ff[NCELL-1:1]};
        end else begin
          nxt_r.byp_ff = tdi;
        end
      end
      ST_UP_DR: begin
        if (sel_bsr) begin
          nxt_r.upd_ff = r.bsr_ff;
        end
      end
      default: begin
      end
    endcase
    // Built from the next values so the level settles at the same
    // edge: the test clock may stop right after an update.
    nxt_r.qz_ff = (nxt_r.ir_ff == INS_SAMPLEZ) ||
                  ((nxt_r.ir_ff == INS_EXTEST) &&
                   !nxt_r.upd_ff[OE_CELL]);
    // Output changes on the falling edge in a real port; here one
    // tck after the shift state, registered.
    nxt_r.oe_n_ff = !((r.st_ff == ST_SH_DR) || (r.st_ff == ST_SH_IR));
    if (r.st_ff == ST_SH_IR) begin
      nxt_r.tdo_ff = r.ir_sh_ff[0];
    end else if (r.ir_ff == INS_IDCODE) begin
      nxt_r.tdo_ff = r.dr_id_ff[0];
    end else if (sel_bsr) begin
      nxt_r.tdo_ff = r.bsr_ff[0];
    end else begin
      nxt_r.tdo_ff = r.byp_ff;
    end
  end
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      r <= '{st_ff: ST_RESET, ir_ff: INS_IDCODE,
             upd_ff: NCELL'(1) << OE_CELL,
             oe_n_ff: 1'b1, default: '0};
    end else begin
      r <= nxt_r;
    end
  end
  assign tdo = r.tdo_ff;
  assign tdo_oe_n = r.oe_n_ff;
  assign cell_out = r.upd_ff;
  assign ext_mode = (r.ir_ff == INS_EXTEST);
  // ==========================================================
  // Tristate control into the memory clock domain
  sjtap_sync #(.W(1)) u_qz (
    .clk(ref_clk),
    .rstn(rstn),
    .d(r.qz_ff),
    .q(q_off_sync)
  );
  assign q_oe_n = q_off_sync;
  // ==========================================================
  // Checks
  property p_reset_id;
    @(posedge tck) disable iff (!rstn)
      r.st_ff == ST_RESET |=> r.ir_ff == INS_IDCODE;
  endproperty
  a_reset_id: assert property (p_reset_id) else $error("no id at reset");
  property p_ir_update;
    @(posedge tck) disable iff (!rstn)
      r.st_ff == ST_UP_IR |=> r.ir_ff == $past(r.ir_sh_ff);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("ir not updated");
  property p_ir_hold;
    @(posedge tck) disable iff (!rstn)
      (r.st_ff != ST_UP_IR && r.st_ff != ST_RESET) |=> $stable(r.ir_ff);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("ir changed early");
  property p_id_cap;
    @(posedge tck) disable iff (!rstn)
      (r.st_ff == ST_CAP_DR && r.ir_ff == INS_IDCODE) |=>
        r.dr_id_ff[0] == 1'b1 && r.dr_id_ff[11:1] == ID_MAKER;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("bad id capture");
  property p_id_hi;
    @(posedge tck) disable iff (!rstn)
      (r.st_ff == ST_CAP_DR && r.ir_ff == INS_IDCODE) |=>
        r.dr_id_ff[31:12] == {ID_REV, ID_PART};
  endproperty
  a_id_hi: assert property (p_id_hi) else $error("bad id upper");
  property p_bsr_cap;
    @(posedge tck) disable iff (!rstn)
      (r.st_ff == ST_CAP_DR && sel_bsr) |=> r.bsr_ff == $past(pin_in);
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("bsr no capture");
  property p_sz;
    @(posedge tck) disable iff (!rstn)
      r.ir_ff == INS_SAMPLEZ |-> r.qz_ff;
  endproperty
  a_sz: assert property (p_sz) else $error("not high z");
  property p_sample;
    @(posedge tck) disable iff (!rstn)
      (r.ir_ff == INS_SAMPLE || r.ir_ff == INS_BYPASS) |-> !r.qz_ff;
  endproperty
  a_sample: assert property (p_sample) else $error("outputs off");
  property p_byp;
    @(posedge tck) disable iff (!rstn)
      (r.st_ff == ST_SH_DR && r.ir_ff == INS_BYPASS) ##1
        (r.st_ff == ST_SH_DR) |=> r.tdo_ff == $past(tdi, 2);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass path");
  property p_oe_cell;
    @(posedge tck) disable iff (!rstn)
      (r.ir_ff == INS_EXTEST && !r.upd_ff[OE_CELL]) |-> r.qz_ff;
  endproperty
  a_oe_cell: assert property (p_oe_cell) else $error("cell 47 ignored");
  property p_preset;
    @(posedge tck) disable iff (!rstn)
      r.st_ff == ST_RESET |=> r.upd_ff[OE_CELL] && !r.qz_ff;
  endproperty
  a_preset: assert property (p_preset) else $error("cell not preset");
  property p_ir_out;
    @(posedge tck) disable iff (!rstn)
      r.st_ff == ST_SH_IR |=> r.tdo_ff == $past(r.ir_sh_ff[0]);
  endproperty
  a_ir_out: assert property (p_ir_out) else $error("ir not shifted out");
  property p_oe_shift;
    @(posedge tck) disable iff (!rstn)
      (r.st_ff == ST_SH_DR || r.st_ff == ST_SH_IR) |=> !r.oe_n_ff;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("tdo not driven");
  c_sample: cover property (@(posedge tck) r.ir_ff == INS_SAMPLE);
  c_ext: cover property (@(posedge tck) r.ir_ff == INS_EXTEST);
  c_sz: cover property (@(posedge tck) r.ir_ff == INS_SAMPLEZ);
  c_byp: cover property (@(posedge tck) r.ir_ff == INS_BYPASS);
endmodule

/* verif/sjtap_ctl.sv */
/*
 Board scan controller model: makes the test clock only while it
 walks the state machine, drives mode select and serial data.
 Assumes the port samples on the rising test clock edge.
*/
`timescale 1ns/1ps
module sjtap_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 48 ns test clock; drive in low phase, sample after rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #24 tck = 1'b1;
    #12 o = tdo;
    #12 tck = 1'b0;
  endtask
  // Idle to idle through one scan, least significant bit first
  task automatic scan(input logic ir, input int n,
      input logic [127:0] din, output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) begin
      step(1'b1, 1'b0, o);
    end
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule

/* verif/sjtap_top_tb.sv */
/*
 Self-checking bench of the test access port with a scan controller.
 Assumes the package constants and the port's hand-over timing.
*/
`timescale 1ns/1ps
module sjtap_top_tb import sjtap_pkg::*; ();
  logic ref_clk, rstn, tck, tms, tdi, tdo, tdo_oe_n, ext_mode, q_oe_n, o;
  logic [BSR_LEN-1:0] pin_in, cell_out;
  logic [127:0] got, din, pins;
  int mismatches, num_checks;
  sjtap_top #(.NCELL(BSR_LEN)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_in(pin_in), .cell_out(cell_out), .ext_mode(ext_mode),
    .q_oe_n(q_oe_n));
  sjtap_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk_scan(input logic [127:0] g, e, input string s);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t %s", $time, s);
    end
  endtask
  task automatic chk_pin(input logic g, e, input string s);
    chk_scan({127'h0, g}, {127'h0, e}, s);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Synchroniser settles in two to three cycles, then bounded wait
  task automatic wait_q(input logic e);
    int k;
    k = 0;
    repeat (3) @(negedge ref_clk);
    while (q_oe_n !== e && k < 8) begin
      @(negedge ref_clk);
      k++;
    end
    chk_pin(q_oe_n, e, "output enable");
    if (k == 8) begin
      stop_test();
    end
  endtask
  task automatic load(input logic [2:0] c);
    ctl.scan(1'b1, IR_LEN, {125'h0, c}, got);
    chk_scan(got, {125'h0, IR_CAPTURE}, "instruction capture");
  endtask
  task automatic bsr(input logic c47);
    @(negedge ref_clk);
    pins = {$urandom, $urandom, $urandom, $urandom};
    pin_in = pins[BSR_LEN-1:0];
    din = {$urandom, $urandom, $urandom, $urandom};
    din[OE_CELL] = c47;
    ctl.scan(1'b0, BSR_LEN, din, got);
    chk_scan(got, {21'h0, pin_in}, "capture");
    chk_scan({21'h0, cell_out}, {21'h0, din[106:0]}, "update");
  endtask
  task automatic id_scan();
    ctl.scan(1'b0, ID_LEN, 128'h0, got);
    chk_scan(got, {96'h0, ID_REV, ID_PART, ID_MAKER, 1'b1}, "id");
  endtask
  initial begin
    #1000000 mismatches++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    pin_in = '0;
    void'($urandom(1));
    ctl.step(1'b1, 1'b0, o);
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    chk_scan({21'h0, cell_out}, 128'h8000_0000_0000, "preset");
    ctl.step(1'b0, 1'b0, o);
    id_scan();
    load(INS_BYPASS);
    din = {$urandom, $urandom, $urandom, $urandom};
    ctl.scan(1'b0, 9, din, got);
    chk_scan(got, {119'h0, din[7:0], 1'b0}, "bypass");
    ctl.step(1'b1, 1'b0, o);
    repeat (3) ctl.step(1'b0, 1'b0, o);
    chk_pin(tdo_oe_n, 1'b0, "tdo enable in shift");
    repeat (2) ctl.step(1'b1, 1'b0, o);
    ctl.step(1'b0, 1'b0, o);
    chk_pin(tdo_oe_n, 1'b1, "tdo enable idle");
    load(INS_SAMPLE);
    bsr(1'b0);
    wait_q(1'b0);
    load(INS_SAMPLEZ);
    wait_q(1'b1);
    bsr(1'b0);
    chk_pin(ext_mode, 1'b0, "mode");
    load(INS_EXTEST);
    chk_pin(ext_mode, 1'b1, "mode");
    wait_q(1'b1);
    bsr(1'b1);
    wait_q(1'b0);
    bsr(1'b0);
    wait_q(1'b1);
    repeat (5) ctl.step(1'b1, 1'b0, o);
    ctl.step(1'b0, 1'b0, o);
    chk_pin(cell_out[OE_CELL], 1'b1, "cell preset");
    chk_pin(ext_mode, 1'b0, "mode");
    wait_q(1'b0);
    id_scan();
    stop_test();
  end
endmodule
